//--- rtl/fsa_pkg.sv
// fsa_pkg: constants and types of the fieldbus slave alarm and acyclic block
package fsa_pkg;
  // ==========================================================
  // sizes
  localparam int FSA_NUM_OBJ   = 4;    // slot/index table entries
  localparam int FSA_MEM_BYTES = 256;  // host byte buffer
  localparam int FSA_DIAG_BYTES = 32;  // diagnostics alarm copy
  localparam int FSA_DIAG_AW   = 5;    // index width of the copy
  localparam logic [7:0] FSA_HDR_BYTES = 8'h04; // length,type,slot,specifier
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] FSA_A_CTRL    = 8'h00;
  localparam logic [7:0] FSA_A_CONFIG  = 8'h04;
  localparam logic [7:0] FSA_A_STATUS  = 8'h08;
  localparam logic [7:0] FSA_A_IRQ_STS = 8'h0C;
  localparam logic [7:0] FSA_A_IRQ_MSK = 8'h10;
  localparam logic [7:0] FSA_A_ALM_BASE = 8'h14;
  localparam logic [7:0] FSA_A_MEM_ADDR = 8'h18;
  localparam logic [7:0] FSA_A_MEM_DATA = 8'h1C;
  localparam logic [3:0] FSA_A_OBJ_HI  = 4'h4;  // 0x40..0x4C, one word per entry
  // ==========================================================
  // field positions
  localparam int FSA_C_SLAVE = 0;   // ctrl: slave role
  localparam int FSA_C_ALREQ = 1;   // ctrl: alarm_request_bit
  localparam int FSA_C_STN   = 8;   // ctrl: station_select [15:8]
  localparam int FSA_C_CSUM  = 16;  // ctrl: mapping_checksum [31:16]
  localparam int FSA_G_STN   = 0;   // config: actual station [7:0]
  localparam int FSA_G_CSUM  = 16;  // config: own checksum [31:16]
  localparam int FSA_S_ACK   = 0;   // status: alarm_ack_flag
  localparam int FSA_S_PEND  = 1;   // status: alarm pending
  localparam int FSA_S_STNMM = 2;   // status: station_mismatch_flag
  localparam int FSA_S_MAPMM = 3;   // status: mapping_mismatch_flag
  localparam int FSA_EV_ACK  = 0;   // event: alarm acknowledged
  localparam int FSA_EV_WR   = 1;   // event: acyclic write stored
  localparam int FSA_EV_MISS = 2;   // event: acyclic request refused
  localparam int FSA_NEV     = 3;
  // ==========================================================
  // types
  typedef enum logic [1:0] {FSA_IDLE, FSA_FETCH, FSA_PEND} fsa_alarm_type;

  typedef struct packed {
    logic [7:0] size;   // bytes, 0 = entry unused
    logic [7:0] base;   // first byte in host buffer
    logic [7:0] index;
    logic [7:0] slot;
  } fsa_obj_type;

  typedef struct packed {
    logic       valid;  // one-cycle request
    logic       write;  // 1 = write, 0 = read
    logic       alarm;  // 1 = alarm read
    logic [7:0] slot;
    logic [7:0] index;
    logic [7:0] offset; // byte within object or alarm record
    logic [7:0] wdata;
  } fsa_req_type;

  typedef struct packed {
    logic       valid;
    logic       ok;
    logic [7:0] data;
  } fsa_rsp_type;
endpackage

//--- rtl/fsa_top.sv
// fsa_top: fieldbus slave acyclic access, alarm raise and mapping checks
// ==========================================================
// What this block does
// R1: acyclic service only in slave role
// R2: table of slot/index to buffer and size
// R3: matching request served from its buffer
// R4: bytes read from / written to buffer
// R5: alarms only in slave role
// R6: alarm raised on request bit rising edge
// R7: one alarm outstanding until acknowledged
// R8: alarm record copied into slave diagnostics
// R9: alarm read answered from that record
// R10: acknowledge sets alarm_ack_flag for host
// R11: record is length,type,slot,specifier,payload
// R12: specifier codes 0..3 carried as given
// R13: host writes station_select for binding
// R14: host checksum checked against own one
// R15: alarm type byte copied unchanged
// R16: mapping_mismatch_flag follows checksum compare
// R17: station_mismatch_flag when station differs
`timescale 1ns/1ps
module fsa_top import fsa_pkg::*; (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // master requests and answers
  input  wire fsa_req_type MS_REQ,
  input  wire logic        MS_ALARM_ACK,
  output fsa_rsp_type      MS_RSP,
  output logic             ALARM_NOTIFY,
  output logic             ALARM_PENDING,
  // interrupt
  output logic             IRQ
);

  // ==========================================================
  // state
  typedef struct packed {
    fsa_obj_type [FSA_NUM_OBJ-1:0] obj;  // slot/index table
    logic                slave;      // slave role enable
    logic                alreq;      // alarm_request_bit
    logic                alreq_prev; // for edge detection
    logic [7:0]          stn_sel;    // station_select
    logic [15:0]         csum;       // mapping_checksum from host
    logic [7:0]          own_stn;    // actual station address
    logic [15:0]         own_csum;   // checksum of mapping in use
    logic [FSA_NEV-1:0]  irq_sts;    // sticky events
    logic [FSA_NEV-1:0]  irq_msk;    // event enables
    logic [7:0]          alm_base;   // alarm record in host buffer
    logic [7:0]          mem_addr;   // host buffer pointer
    fsa_alarm_type       st;         // alarm sequencer
    logic [7:0]          cnt;        // record byte being copied
    logic [7:0]          len;        // bytes held in diagnostics
    logic                ack_flag;   // alarm_ack_flag
    logic                stn_mm;     // station_mismatch_flag
    logic                map_mm;     // mapping_mismatch_flag
    logic                notify;     // alarm notification pulse
    logic                pend;       // alarm outstanding
    logic                irq;
    logic [31:0]         rdata;
    fsa_rsp_type         rsp;
  } fsa_regs_type;

  // all state but the two byte buffers lives in one struct so reset and update are one line each
  fsa_regs_type q;  // registered state
  fsa_regs_type d;  // next state

  // host buffer and diagnostics copy
  logic [7:0] host_mem [FSA_MEM_BYTES];
  logic [7:0] diag_mem [FSA_DIAG_BYTES];

  logic                   mem_we;  // host buffer write
  logic [7:0]             mem_wa;
  logic [7:0]             mem_wd;
  logic                   diag_we; // diagnostics write
  logic [FSA_DIAG_AW-1:0] diag_wa;
  logic [7:0]             diag_wd;

  // ==========================================================
  // next-state logic
  // one pass computes next values from q and the ports, irq_sts and irq from d; a later section
  // overrides an earlier one only where both touch the same field
  always_comb begin
    logic              hit;
    fsa_obj_type       sel;
    logic [7:0]        baddr;
    logic [8:0]        rec_len;
    logic [FSA_NEV-1:0] ev;
    hit     = 1'b0;
    sel     = '0;
    baddr   = '0;
    rec_len = '0;
    ev      = '0;
    d       = q;
    d.rdata = '0;
    d.rsp   = '0;
    d.notify = 1'b0;
    mem_we  = 1'b0;
    mem_wa  = '0;
    mem_wd  = '0;
    diag_we = 1'b0;
    diag_wa = '0;
    diag_wd = '0;

    // register writes
    // table decode sits outside the case so the entry words share one path
    if (REG_WR) begin
      if (REG_ADDR[7:4] == FSA_A_OBJ_HI) begin
        // R2: table entry
        d.obj[REG_ADDR[3:2]] = REG_WDATA;
      end
      unique case (REG_ADDR)
        FSA_A_CTRL: begin
          d.slave   = REG_WDATA[FSA_C_SLAVE];
          d.alreq   = REG_WDATA[FSA_C_ALREQ];
          // R13: host binds output image to station
          d.stn_sel = REG_WDATA[FSA_C_STN +: 8];
          d.csum    = REG_WDATA[FSA_C_CSUM +: 16];
        end
        FSA_A_CONFIG: begin
          d.own_stn  = REG_WDATA[FSA_G_STN +: 8];
          d.own_csum = REG_WDATA[FSA_G_CSUM +: 16];
        end
        FSA_A_IRQ_STS: d.irq_sts = q.irq_sts & ~REG_WDATA[FSA_NEV-1:0];
        FSA_A_IRQ_MSK: d.irq_msk = REG_WDATA[FSA_NEV-1:0];
        FSA_A_ALM_BASE: d.alm_base = REG_WDATA[7:0];
        FSA_A_MEM_ADDR: d.mem_addr = REG_WDATA[7:0];
        FSA_A_MEM_DATA: begin
          // pointer steps so a buffer loads as a stream
          mem_we     = 1'b1;
          mem_wa     = q.mem_addr;
          mem_wd     = REG_WDATA[7:0];
          d.mem_addr = q.mem_addr + 8'h01;
        end
        default: ;  // unmapped writes are dropped
      endcase
    end

    // register reads, answered next cycle; unmapped reads give zero
    // a read has no side effect: the buffer pointer steps on writes only
    if (REG_RD) begin
      if (REG_ADDR[7:4] == FSA_A_OBJ_HI) begin
        d.rdata = q.obj[REG_ADDR[3:2]];
      end
      unique case (REG_ADDR)
        FSA_A_CTRL: d.rdata = {q.csum, q.stn_sel, 6'h00, q.alreq, q.slave};
        FSA_A_CONFIG: d.rdata = {q.own_csum, 8'h00, q.own_stn};
        FSA_A_STATUS: d.rdata = {28'h0000000, q.map_mm, q.stn_mm, q.pend, q.ack_flag};
        FSA_A_IRQ_STS: d.rdata = {29'h0, q.irq_sts};
        FSA_A_IRQ_MSK: d.rdata = {29'h0, q.irq_msk};
        FSA_A_ALM_BASE: d.rdata = {24'h000000, q.alm_base};
        FSA_A_MEM_ADDR: d.rdata = {24'h000000, q.mem_addr};
        FSA_A_MEM_DATA: d.rdata = {24'h000000, host_mem[q.mem_addr]};
        default: ;
      endcase
    end

    // table lookup: lowest matching entry wins
    // a size of zero marks an unused entry, so a cleared table never matches
    // trade-off: a linear scan keeps entries in flops, fine for a handful
    for (int i = 0; i < FSA_NUM_OBJ; i++) begin
      if (!hit && q.obj[i].size != 8'h00 && q.obj[i].slot == MS_REQ.slot &&
          q.obj[i].index == MS_REQ.index) begin
        hit = 1'b1;
        sel = q.obj[i];
      end
    end
    baddr = 8'(sel.base + MS_REQ.offset);

    // acyclic requests from the master, answered next cycle
    // every request gets exactly one answer; a refusal is ok low, data zero
    if (MS_REQ.valid) begin
      d.rsp.valid = 1'b1;
      if (!q.slave) begin
        // R1: service absent outside slave role
        d.rsp.ok = 1'b0;
      end else if (MS_REQ.alarm) begin
        // R9: alarm read served from diagnostics copy
        if (q.st == FSA_PEND && MS_REQ.offset < q.len) begin
          d.rsp.ok   = 1'b1;
          d.rsp.data = diag_mem[MS_REQ.offset[FSA_DIAG_AW-1:0]];
        end
      end else if (hit && MS_REQ.offset < sel.size) begin
        // R3: matched slot and index served
        d.rsp.ok = 1'b1;
        // R4: byte from or into the object array
        if (MS_REQ.write) begin
          mem_we        = 1'b1;  // overrides a host write in the same cycle
          mem_wa        = baddr;
          mem_wd        = MS_REQ.wdata;
          ev[FSA_EV_WR] = 1'b1;
        end else begin
          d.rsp.data = host_mem[baddr];
        end
      end
      // refusals set a sticky event so software can spot probes of unknown objects
      ev[FSA_EV_MISS] = ~d.rsp.ok;
    end

    // alarm sequencer
    // the previous level is taken every cycle, so an edge seen while busy
    // is consumed, not queued; software must go 0 then 1 again
    d.alreq_prev = q.alreq;
    unique case (q.st)
      FSA_IDLE: begin
        // R5: only in slave role
        // R6: rising edge of alarm_request_bit
        if (q.slave && q.alreq && !q.alreq_prev) begin
          // R11: length byte plus four header bytes
          rec_len    = {1'b0, host_mem[q.alm_base]} + {1'b0, FSA_HDR_BYTES};
          // long records are clipped to the diagnostics space
          d.len      = (rec_len > 9'(FSA_DIAG_BYTES)) ? 8'(FSA_DIAG_BYTES) : rec_len[7:0];
          d.cnt      = 8'h00;
          d.ack_flag = 1'b0;
          d.st       = FSA_FETCH;
        end
      end
      FSA_FETCH: begin
        // the master hears of the alarm only after the last byte lands,
        // so an alarm read never sees a half-written record
        // R8: copy record into diagnostics, one byte a cycle
        // R12: specifier byte and R15: type byte copied unchanged
        diag_we = 1'b1;
        diag_wa = q.cnt[FSA_DIAG_AW-1:0];
        diag_wd = host_mem[8'(q.alm_base + q.cnt)];
        d.cnt   = q.cnt + 8'h01;
        if (!q.slave) begin
          d.st = FSA_IDLE;
        end else if (q.cnt == q.len - 8'h01) begin
          d.st     = FSA_PEND;
          d.pend   = 1'b1;
          d.notify = 1'b1;
        end
      end
      FSA_PEND: begin
        // leaving slave role drops the alarm without setting the ack flag
        // R7: further edges ignored until acknowledge
        if (!q.slave) begin
          d.st   = FSA_IDLE;
          d.pend = 1'b0;
        end else if (MS_ALARM_ACK) begin
          // R10: tell host the next alarm may be raised
          d.st            = FSA_IDLE;
          d.pend          = 1'b0;
          d.ack_flag      = 1'b1;
          ev[FSA_EV_ACK]  = 1'b1;
        end
      end
      default: d.st = FSA_IDLE;
    endcase

    // compared every cycle; the flags follow field writes one cycle late
    // R14: host checksum checked against own
    // R16: mapping mismatch follows compare
    d.map_mm = (q.csum != q.own_csum);
    // R17: station mismatch follows compare
    d.stn_mm = (q.stn_sel != q.own_stn);

    // events set after the clear so a same-cycle event survives
    d.irq_sts = d.irq_sts | ev;
    // formed from next status and mask, so the line is high in exactly
    // the cycles in which an unmasked status bit is set
    d.irq     = |(d.irq_sts & d.irq_msk);
  end

  // ==========================================================
  // state register
  // synchronous reset: role off, table empty, no alarm, all outputs low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // buffers: no reset, contents are software's to load
  // limitation: the diagnostics copy holds the first 32 record bytes only
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      host_mem[mem_wa] <= mem_wd;
    end
    if (diag_we) begin
      diag_mem[diag_wa] <= diag_wd;
    end
  end

  // outputs straight from flip-flops
  // every port is a field of q, so nothing is decoded after the flops
  assign REG_RDATA     = q.rdata;
  assign MS_RSP        = q.rsp;
  assign ALARM_NOTIFY  = q.notify;
  assign ALARM_PENDING = q.pend;
  assign IRQ           = q.irq;

endmodule

//--- tb/fsa_master_model.sv
// fsa_master_model: behavioural fieldbus master for acyclic and alarm traffic
`timescale 1ns/1ps
module fsa_master_model import fsa_pkg::*; (
  // clock
  input wire logic        clk,
  // requests
  output fsa_req_type     req,
  output logic            ack,
  // answers
  input wire fsa_rsp_type rsp
);
  initial begin
    req = '0;
    ack = 1'b0;
  end
  // one byte transfer; gap idle cycles make the master slow
  task automatic xfer(input logic w, input logic a, input logic [7:0] s, input logic [7:0] x,
                      input logic [7:0] o, input logic [7:0] d, input int gap,
                      output fsa_rsp_type r);
    repeat (gap) @(posedge clk);
    req <= fsa_req_type'{1'b1, w, a, s, x, o, d};
    @(posedge clk);
    // released fields flip so a stale value is never trusted
    req <= ~fsa_req_type'{1'b1, w, a, s, x, o, d};
    @(posedge clk);
    r = rsp;
  endtask
  // alarm acknowledge pulse after gap idle cycles
  task automatic ack_alarm(input int gap);
    repeat (gap) @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
  endtask
endmodule

//--- tb/fsa_top_asserts.sv
// fsa_top_asserts: port checker for the slave alarm block
`timescale 1ns/1ps
module fsa_top_asserts import fsa_pkg::*; (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // register read
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // master side
  input wire fsa_req_type MS_REQ,
  input wire logic        MS_ALARM_ACK,
  input wire fsa_rsp_type MS_RSP,
  input wire logic        ALARM_NOTIFY,
  input wire logic        ALARM_PENDING
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ==========
  // steps of an alarm
  sequence ack_s; ALARM_PENDING && MS_ALARM_ACK; endsequence
  sequence raise_s; ALARM_NOTIFY && ALARM_PENDING; endsequence
  // ==========
  // answers and alarm lifecycle
  rsp_next_a: assert property (MS_REQ.valid |=> MS_RSP.valid)
    else $error("late answer");
  rsp_spur_a: assert property (!MS_REQ.valid |=> !MS_RSP.valid)
    else $error("answer without request");
  rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h0)
    else $error("stray read data");
  alarm_refuse_a: assert property (MS_REQ.alarm && !ALARM_PENDING |=> !MS_RSP.ok)
    else $error("alarm read served while idle");
  notify_pend_a: assert property (ALARM_NOTIFY |-> raise_s)
    else $error("notify without pending");
  notify_once_a: assert property (raise_s |=> !ALARM_NOTIFY)
    else $error("notify longer than one cycle");
  one_alarm_a: assert property (ALARM_NOTIFY |-> !$past(ALARM_PENDING))
    else $error("second alarm while pending");
  pend_rise_a: assert property ($rose(ALARM_PENDING) |-> ALARM_NOTIFY)
    else $error("pending rose without notify");
  ack_clear_a: assert property (ack_s |=> !ALARM_PENDING)
    else $error("pending kept after ack");
endmodule
bind fsa_top fsa_top_asserts u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .MS_REQ(MS_REQ), .MS_ALARM_ACK(MS_ALARM_ACK), .MS_RSP(MS_RSP),
  .ALARM_NOTIFY(ALARM_NOTIFY), .ALARM_PENDING(ALARM_PENDING));

//--- tb/fsa_top_tb.sv
// fsa_top_tb: self-checking bench for the slave alarm block
`timescale 1ns/1ps
module fsa_top_tb import fsa_pkg::*;;
  // ==========
  // control words: station 5, checksum 1234, slave role on
  localparam logic [31:0] CTL = 32'h1234_0501;
  localparam logic [31:0] CFG = 32'h1234_0005;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  fsa_req_type req;
  fsa_rsp_type rsp;
  logic        ack, notify, pending, irq;
  int          n_fail = 0;
  int          total_checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  fsa_top uut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
    .REG_RD(rd_s), .REG_RDATA(rdata), .MS_REQ(req), .MS_ALARM_ACK(ack), .MS_RSP(rsp),
    .ALARM_NOTIFY(notify), .ALARM_PENDING(pending), .IRQ(irq));
  fsa_master_model m (.clk(clk), .req(req), .ack(ack), .rsp(rsp));
  // ==========
  // shared compare and register cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask
  // station and checksum compare, unmapped read
  task automatic t_status();
    rc(FSA_A_STATUS, 32'h0);
    rc(8'h2C, 32'h0);
    wr(FSA_A_CONFIG, CFG);
    wr(FSA_A_CTRL, CTL ^ 32'h0000_0300);
    rc(FSA_A_STATUS, 32'h4);
    wr(FSA_A_CTRL, CTL ^ 32'h0001_0000);
    rc(FSA_A_STATUS, 32'h8);
    wr(FSA_A_CTRL, CTL);
    rc(FSA_A_STATUS, 32'h0);
    $display("test status done");
  endtask
  // acyclic reads and writes, refusals, write interrupt
  task automatic t_acyc();
    fsa_rsp_type r;
    // slave role off with a request edge: no service and no alarm
    wr(FSA_A_CTRL, CTL ^ 32'h0000_0003);
    m.xfer(1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00, 0, r);
    chk(32'({r.valid, r.ok}), 32'h2);
    repeat (8) @(posedge clk);
    chk(32'(pending), 32'h0);
    wr(FSA_A_CTRL, CTL);
    wr(FSA_A_IRQ_STS, 32'h7);
    wr(FSA_A_IRQ_MSK, 32'h2);
    // slot 1 index 0, base 0x80, ten bytes
    wr(8'h40, 32'h0A80_0001);
    m.xfer(1'b1, 1'b0, 8'h01, 8'h00, 8'h09, 8'h5A, 3, r);
    chk(32'({r.valid, r.ok}), 32'h3);
    rc(FSA_A_IRQ_STS, 32'h2);
    chk(32'(irq), 32'h1);
    m.xfer(1'b0, 1'b0, 8'h01, 8'h00, 8'h09, 8'h00, 0, r);
    chk(32'(r), 32'h35A);
    m.xfer(1'b0, 1'b0, 8'h01, 8'h00, 8'h0A, 8'h00, 0, r);
    chk(32'({r.valid, r.ok}), 32'h2);
    wr(FSA_A_MEM_ADDR, 32'h89);
    rc(FSA_A_MEM_DATA, 32'h5A);
    wr(FSA_A_IRQ_STS, 32'h7);
    // one idle cycle before looking at the interrupt
    @(posedge clk);
    chk(32'(irq), 32'h0);
    $display("test acyclic done");
  endtask
  // four alarms, one per specifier code
  task automatic t_alarm();
    fsa_rsp_type r;
    logic [7:0]  rec [6];
    int          n;
    for (int k = 0; k < 4; k++) begin
      rec = '{8'h02, 8'(k + 1), 8'h03, 8'(k), 8'h11, 8'h22};
      wr(FSA_A_MEM_ADDR, 32'h0);
      foreach (rec[i]) wr(FSA_A_MEM_DATA, 32'(rec[i]));
      wr(FSA_A_CTRL, CTL | 32'h2);
      n = 0;
      while (notify !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      // copy of 2 + 4 bytes, one cycle past the write
      chk(32'(n), 32'h7);
      rc(FSA_A_STATUS, 32'h2);
      // a fresh rising edge while pending must be dropped
      wr(FSA_A_CTRL, CTL);
      wr(FSA_A_CTRL, CTL | 32'h2);
      foreach (rec[i]) begin
        m.xfer(1'b0, 1'b1, 8'h00, 8'h00, 8'(i), 8'h00, i % 2, r);
        chk(32'(r), 32'h300 | 32'(rec[i]));
      end
      m.xfer(1'b0, 1'b1, 8'h00, 8'h00, 8'h06, 8'h00, 0, r);
      chk(32'({r.valid, r.ok}), 32'h2);
      m.ack_alarm(k);
      chk(32'(pending), 32'h0);
      rc(FSA_A_STATUS, 32'h1);
      rc(FSA_A_IRQ_STS, 32'h5);
      wr(FSA_A_IRQ_STS, 32'h5);
      repeat (12) @(posedge clk);
      chk(32'(pending), 32'h0);
      // an alarm read with nothing outstanding is refused
      m.xfer(1'b0, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 0, r);
      chk(32'({r.valid, r.ok}), 32'h2);
      wr(FSA_A_CTRL, CTL);
    end
    $display("test alarm done");
  endtask
  // ==========
  // verdict and run control
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_status();
    t_acyc();
    t_alarm();
    print_verdict();
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #(20 * 20000);
    n_fail++;
    print_verdict();
  end
endmodule
